// ---- hdl/uart_irq_pkg.sv ----
package uart_irq_pkg;

  // internal register addresses seen on the host-port register strobe bus
  localparam logic [2:0] ADDR_HOLD       = 3'h0;
  localparam logic [2:0] ADDR_ISR_QCTL   = 3'h2;
  localparam logic [2:0] ADDR_PIN_LEVEL  = 3'h4;
  localparam logic [2:0] ADDR_LINE       = 3'h5;
  localparam logic [2:0] ADDR_MODEM      = 3'h6;

  // queue_control field positions
  localparam int QC_FIFO_EN  = 0;
  localparam int QC_RX_RST   = 1;
  localparam int QC_TX_RST   = 2;
  localparam int QC_WAKE_EN  = 3;
  localparam int QC_TX_SEL   = 4;
  localparam int QC_RX_SEL   = 6;

  // interrupt_source_status bits 5:0, highest priority first
  localparam logic [5:0] ISR_CODE_LINE     = 6'h06;
  localparam logic [5:0] ISR_CODE_TIMEOUT  = 6'h0C;
  localparam logic [5:0] ISR_CODE_RX_READY = 6'h04;
  localparam logic [5:0] ISR_CODE_TX_READY = 6'h02;
  localparam logic [5:0] ISR_CODE_MODEM    = 6'h00;
  localparam logic [5:0] ISR_CODE_CHAR     = 6'h10;
  localparam logic [5:0] ISR_CODE_FLOW     = 6'h20;
  localparam logic [5:0] ISR_CODE_NONE     = 6'h01;
  localparam logic [7:0] ISR_RESET         = 8'h01;

  localparam logic [1:0] TABLE_A = 2'h0;
  localparam logic [1:0] TABLE_B = 2'h1;
  localparam logic [1:0] TABLE_C = 2'h2;
  localparam logic [1:0] TABLE_D = 2'h3;

  // trigger tables, element index = 2-bit selector
  localparam logic [3:0][7:0] RX_TABLE_A = {8'h0E, 8'h08, 8'h04, 8'h01};
  localparam logic [3:0][7:0] RX_TABLE_B = {8'h1C, 8'h18, 8'h10, 8'h08};
  localparam logic [3:0][7:0] TX_TABLE_B = {8'h1E, 8'h18, 8'h08, 8'h10};
  localparam logic [3:0][7:0] RX_TABLE_C = {8'h3C, 8'h38, 8'h10, 8'h08};
  localparam logic [3:0][7:0] TX_TABLE_C = {8'h38, 8'h20, 8'h10, 8'h08};
  localparam logic [7:0]      TX_LEVEL_A = 8'h01;
  localparam logic [7:0]      NO_FIFO_LEVEL = 8'h01;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic line_err;
    logic rx_timeout;
    logic modem_change;
    logic xonxoff_match;
    logic special_match;
    logic char_received;
    logic cts_rise;
    logic rts_rise;
    logic wakeup;
    logic gpio_event;
  } uart_events_t;

  typedef struct packed {
    logic fifo_en;
    logic rx_rst;
    logic tx_rst;
    logic wake_en;
  } queue_ctl_t;

endpackage

// ---- hdl/uart_interrupt_fifo_control.sv ----
`timescale 1ns/1ps
// What this block does
// - a read of line_condition_status clears a pending line-status interrupt
// - receive ready stays while receive occupancy is at or above its trigger
// - a read of receive_holding clears the receive time-out interrupt
// - a status read that reports it, or a write of transmit_holding, clears the transmit-ready interrupt
// - a read of modem_line_status clears the modem-status interrupt
// - a read of modem_line_status clears CTS/RTS change interrupts
// - a status read clears the Xon/Xoff interrupt when it reports it, and the wake-up interrupt when it reports no source
// - special match clears on a status read that reports it or on the next received character
// - a read of pin_input_level clears the pin interrupt
// - status bits 5:0 carry the priority code of the highest pending source other than wake-up and pin
// - status bit 0 is low while a source other than wake-up or pin is pending, high otherwise and at reset
// - with enhanced features, character matches set status bit 4
// - with enhanced features, CTS or RTS rising sets status bit 5
// - bit 6 inverts bit 7 while a pin interrupt is pending, else equals it
// - status bit 7 shows whether the FIFOs are enabled
// - control bit 0 enables FIFOs; other control bits are ignored when it is 0
// - control bit 1 resets receive pointers and counter, then returns to 0
// - control bit 2 resets transmit pointers and counter, then returns to 0
// - control bit 3 enables wake-up interrupt, only with enhanced features
// - transmit ready rises on falling below trigger, or on empty if never above
// - receive ready rises when occupancy crosses the selected receive trigger
// - one shared table selection applies to both directions
// - table select picks tables A to D; D uses programmed levels
// - a status read returns the top source; lower ones stay queued
module uart_interrupt_fifo_control
  import uart_irq_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire host_req_t        host_req,
  input  wire uart_events_t     events,
  input  wire logic [CNT_W-1:0] rx_count,
  input  wire logic [CNT_W-1:0] tx_count,
  input  wire logic             enhanced_en,
  input  wire logic [1:0]       table_sel,
  input  wire logic [7:0]       prog_rx_level,
  input  wire logic [7:0]       prog_tx_level,
  input  wire logic             pin_irq_enabled,
  output logic [7:0]            isr_value,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  output queue_ctl_t            queue_ctl,
  output logic [7:0]            rx_trigger,
  output logic [7:0]            tx_trigger,
  output logic                  irq_pending
);

  typedef struct packed {
    queue_ctl_t       qc;
    logic [1:0]       rx_sel;
    logic [1:0]       tx_sel;
    logic             line_p;
    logic             tmo_p;
    logic             txr_p;
    logic             msr_p;
    logic             xon_p;
    logic             spc_p;
    logic             flow_p;
    logic             wake_p;
    logic             gpio_p;
    logic             tx_over;
    logic [CNT_W-1:0] tx_prev;
    logic [7:0]       rx_trig;
    logic [7:0]       tx_trig;
    logic [7:0]       interrupt_source_status;
    logic [7:0]       rd_data;
    logic             rd_valid;
    logic             pend;
  } state_t;

  localparam state_t STATE_RESET = '{
    qc: '0, rx_sel: 2'h0, tx_sel: 2'h0, line_p: 1'b0, tmo_p: 1'b0, txr_p: 1'b0,
    msr_p: 1'b0, xon_p: 1'b0, spc_p: 1'b0, flow_p: 1'b0, wake_p: 1'b0,
    gpio_p: 1'b0, tx_over: 1'b0, tx_prev: '0, rx_trig: NO_FIFO_LEVEL,
    tx_trig: NO_FIFO_LEVEL, interrupt_source_status: ISR_RESET, rd_data: 8'h00, rd_valid: 1'b0,
    pend: 1'b0};

  state_t st_r;
  state_t st_nxt;

  logic rd_isr, rd_line, rd_modem, rd_hold, rd_pin, wr_hold, wr_qctl;
  logic tx_set, rx_ready, any_pend;

  // occupancy counts may be narrower than the 8-bit trigger levels; a zero-width
  // pad would be illegal when they are equal, so the cast widens instead
  function automatic logic [7:0] widen(input logic [CNT_W-1:0] cnt);
    return 8'(cnt);
  endfunction

  // one table selector serves both directions, so a late table write retunes both
  function automatic logic [7:0] trig_level(input logic [1:0] tbl, input logic [1:0] sel,
                                            input logic is_tx, input logic [7:0] prog);
    logic [7:0] lvl;
    lvl = 8'h00;
    case (tbl)
      TABLE_A: lvl = is_tx ? TX_LEVEL_A : RX_TABLE_A[sel];
      TABLE_B: lvl = is_tx ? TX_TABLE_B[sel] : RX_TABLE_B[sel];
      TABLE_C: lvl = is_tx ? TX_TABLE_C[sel] : RX_TABLE_C[sel];
      default: lvl = prog;
    endcase
    return lvl;
  endfunction

  assign rd_isr   = host_req.rd && host_req.addr == ADDR_ISR_QCTL;
  assign rd_line  = host_req.rd && host_req.addr == ADDR_LINE;
  assign rd_modem = host_req.rd && host_req.addr == ADDR_MODEM;
  assign rd_hold  = host_req.rd && host_req.addr == ADDR_HOLD;
  assign rd_pin   = host_req.rd && host_req.addr == ADDR_PIN_LEVEL;
  assign wr_hold  = host_req.wr && host_req.addr == ADDR_HOLD;
  assign wr_qctl  = host_req.wr && host_req.addr == ADDR_ISR_QCTL;

  always_comb begin
    logic below_now;
    logic below_prev;
    logic [5:0] code;
    st_nxt     = st_r;
    below_now  = 1'b0;
    below_prev = 1'b0;
    code       = ISR_CODE_NONE;

    // queue_control write; without bit 0 the rest is not programmed
    st_nxt.qc.rx_rst = 1'b0;
    st_nxt.qc.tx_rst = 1'b0;
    if (wr_qctl) begin
      st_nxt.qc.fifo_en = host_req.wdata[QC_FIFO_EN];
      if (host_req.wdata[QC_FIFO_EN]) begin
        st_nxt.qc.rx_rst = host_req.wdata[QC_RX_RST];
        st_nxt.qc.tx_rst = host_req.wdata[QC_TX_RST];
        st_nxt.rx_sel    = host_req.wdata[QC_RX_SEL +: 2];
        if (enhanced_en) begin
          st_nxt.qc.wake_en = host_req.wdata[QC_WAKE_EN];
          st_nxt.tx_sel     = host_req.wdata[QC_TX_SEL +: 2];
        end
      end
    end

    // non-FIFO mode behaves as a one-deep holding register
    if (st_r.qc.fifo_en) begin
      st_nxt.rx_trig = trig_level(table_sel, st_r.rx_sel, 1'b0, prog_rx_level);
      st_nxt.tx_trig = trig_level(table_sel, st_r.tx_sel, 1'b1, prog_tx_level);
    end else begin
      st_nxt.rx_trig = NO_FIFO_LEVEL;
      st_nxt.tx_trig = NO_FIFO_LEVEL;
    end

    // transmit ready event
    below_now  = widen(tx_count) < st_r.tx_trig;
    below_prev = widen(st_r.tx_prev) < st_r.tx_trig;
    tx_set = (below_now && !below_prev)
           || (tx_count == '0 && st_r.tx_prev != '0 && !st_r.tx_over);
    st_nxt.tx_prev = tx_count;
    if (tx_count == '0) begin
      st_nxt.tx_over = 1'b0;
    end else if (!below_now) begin
      st_nxt.tx_over = 1'b1;
    end

    rx_ready = widen(rx_count) >= st_r.rx_trig;

    // clears first; sets below override them in the same cycle
    if (rd_line) begin
      st_nxt.line_p = 1'b0;
    end
    if (rd_hold) begin
      st_nxt.tmo_p = 1'b0;
    end
    if (wr_hold) begin
      st_nxt.txr_p = 1'b0;
    end
    if (rd_modem) begin
      st_nxt.msr_p  = 1'b0;
      st_nxt.flow_p = 1'b0;
    end
    if (rd_pin) begin
      st_nxt.gpio_p = 1'b0;
    end
    if (events.char_received) begin
      st_nxt.spc_p = 1'b0;
    end
    // a status read retires the source it reported only when that is transmit ready or a character match, and wake-up when it reports none; the rest stay queued
    if (rd_isr) begin
      case (st_r.interrupt_source_status[5:0])
        ISR_CODE_TX_READY: st_nxt.txr_p = 1'b0;
        ISR_CODE_CHAR: begin
          st_nxt.xon_p = 1'b0;
          st_nxt.spc_p = 1'b0;
        end
        ISR_CODE_NONE: st_nxt.wake_p = 1'b0;
        default: ;
      endcase
    end

    if (events.line_err)   st_nxt.line_p = 1'b1;
    if (events.rx_timeout) st_nxt.tmo_p = 1'b1;
    if (tx_set)            st_nxt.txr_p = 1'b1;
    if (events.modem_change) st_nxt.msr_p = 1'b1;
    if (enhanced_en && events.xonxoff_match) st_nxt.xon_p = 1'b1;
    if (enhanced_en && events.special_match) st_nxt.spc_p = 1'b1;
    if (enhanced_en && (events.cts_rise || events.rts_rise)) begin
      st_nxt.flow_p = 1'b1;
    end
    if (enhanced_en && st_r.qc.wake_en && events.wakeup) begin
      st_nxt.wake_p = 1'b1;
    end
    if (events.gpio_event) st_nxt.gpio_p = 1'b1;

    // priority encode from current flags
    if (st_r.line_p) begin
      code = ISR_CODE_LINE;
    end else if (st_r.tmo_p) begin
      code = ISR_CODE_TIMEOUT;
    end else if (rx_ready) begin
      code = ISR_CODE_RX_READY;
    end else if (st_r.txr_p) begin
      code = ISR_CODE_TX_READY;
    end else if (st_r.msr_p) begin
      code = ISR_CODE_MODEM;
    end else if (st_r.xon_p || st_r.spc_p) begin
      code = ISR_CODE_CHAR;
    end else if (st_r.flow_p) begin
      code = ISR_CODE_FLOW;
    end else begin
      code = ISR_CODE_NONE;
    end
    any_pend = !code[0];
    st_nxt.pend = any_pend;
    st_nxt.interrupt_source_status[5:0] = code;
    st_nxt.interrupt_source_status[7] = st_r.qc.fifo_en;
    st_nxt.interrupt_source_status[6] = (st_r.gpio_p && pin_irq_enabled) ? !st_r.qc.fifo_en
                                                      : st_r.qc.fifo_en;

    // status read returns the value registered last cycle
    st_nxt.rd_valid = host_req.rd;
    st_nxt.rd_data  = rd_isr ? st_r.interrupt_source_status : 8'h00;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign isr_value   = st_r.interrupt_source_status;
  assign rd_data     = st_r.rd_data;
  assign rd_valid    = st_r.rd_valid;
  assign queue_ctl   = st_r.qc;
  assign rx_trigger  = st_r.rx_trig;
  assign tx_trigger  = st_r.tx_trig;
  assign irq_pending = st_r.pend;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_line_read_clear: assert property (rd_line && !events.line_err |=> !st_r.line_p)
    else $error("line-status flag survived a line status read");

  a_rx_ready_code: assert property (
    st_r.qc.fifo_en && !st_r.line_p && !st_r.tmo_p
    && widen(rx_count) >= st_r.rx_trig
    |=> isr_value[5:0] == ISR_CODE_RX_READY)
    else $error("receive ready not reported at trigger");

  a_timeout_clear: assert property (rd_hold && !events.rx_timeout |=> !st_r.tmo_p)
    else $error("time-out flag survived a holding read");

  a_tx_write_clear: assert property (wr_hold && !tx_set |=> !st_r.txr_p)
    else $error("transmit ready survived a holding write");

  a_modem_read_clear: assert property (
    rd_modem && !events.modem_change && !events.cts_rise && !events.rts_rise
    |=> !st_r.msr_p && !st_r.flow_p)
    else $error("modem or flow flag survived a modem status read");

  a_special_next_char: assert property (
    events.char_received && !events.special_match |=> !st_r.spc_p)
    else $error("special match survived the next character");

  a_pin_read_clear: assert property (rd_pin && !events.gpio_event |=> !st_r.gpio_p)
    else $error("pin interrupt survived a level read");

  a_bit0_pending: assert property (##1 isr_value[0] == !$past(any_pend))
    else $error("status bit 0 disagrees with pending state");

  a_fifo_bit7: assert property (##1 isr_value[7] == $past(st_r.qc.fifo_en))
    else $error("status bit 7 does not follow FIFO enable");

  a_ignore_no_enable: assert property (
    wr_qctl && !host_req.wdata[QC_FIFO_EN]
    |=> !queue_ctl.fifo_en && !queue_ctl.rx_rst && !queue_ctl.tx_rst)
    else $error("control bits acted without FIFO enable");

  a_rx_reset_pulse: assert property (queue_ctl.rx_rst |=> !queue_ctl.rx_rst)
    else $error("receive reset did not self-clear");

  a_tx_reset_pulse: assert property (queue_ctl.tx_rst |=> !queue_ctl.tx_rst)
    else $error("transmit reset did not self-clear");

  // status reads retire transmit ready or a character match when they report it, and wake-up when none is reported; anything else must survive them
  a_status_tx_clear: assert property (
    rd_isr && st_r.interrupt_source_status[5:0] == ISR_CODE_TX_READY && !tx_set
    |=> !st_r.txr_p)
    else $error("transmit ready survived the status read that reported it");

  a_status_char_clear: assert property (
    rd_isr && st_r.interrupt_source_status[5:0] == ISR_CODE_CHAR
    && !events.xonxoff_match && !events.special_match
    |=> !st_r.xon_p && !st_r.spc_p)
    else $error("character match survived the status read that reported it");

  a_wake_status_clear: assert property (
    rd_isr && st_r.interrupt_source_status[5:0] == ISR_CODE_NONE && !events.wakeup
    |=> !st_r.wake_p)
    else $error("wake-up flag survived a status read");

  a_char_match_set: assert property (
    enhanced_en && (events.xonxoff_match || events.special_match)
    |=> st_r.xon_p || st_r.spc_p)
    else $error("character match did not raise its flag");

  a_flow_rise_set: assert property (
    enhanced_en && (events.cts_rise || events.rts_rise)
    |=> st_r.flow_p)
    else $error("flow-control rise did not raise its flag");

  // bit 6 only departs from bit 7 while an enabled pin interrupt waits
  a_pin_bit6_split: assert property (
    st_r.gpio_p && pin_irq_enabled
    |=> isr_value[6] != isr_value[7])
    else $error("bit 6 does not invert bit 7 with a pin interrupt");

  a_pin_bit6_equal: assert property (
    !(st_r.gpio_p && pin_irq_enabled)
    |=> isr_value[6] == isr_value[7])
    else $error("bit 6 differs from bit 7 without a pin interrupt");

  a_wake_needs_enable: assert property (
    !st_r.qc.wake_en && !st_r.wake_p
    |=> !st_r.wake_p)
    else $error("wake-up flag set while wake-up interrupt disabled");

  // a set must win over any clear that lands in the same cycle
  a_tx_ready_set: assert property (
    tx_set
    |=> st_r.txr_p)
    else $error("transmit ready event lost");

  a_line_code_top: assert property (
    st_r.line_p
    |=> isr_value[5:0] == ISR_CODE_LINE)
    else $error("line status not reported at top priority");

  a_no_fifo_level: assert property (
    !st_r.qc.fifo_en
    |=> rx_trigger == NO_FIFO_LEVEL && tx_trigger == NO_FIFO_LEVEL)
    else $error("trigger level not one while FIFOs are off");

  a_table_shared: assert property (
    st_r.qc.fifo_en && table_sel == TABLE_D
    |=> rx_trigger == $past(prog_rx_level) && tx_trigger == $past(prog_tx_level))
    else $error("programmed table not applied to both directions");

  a_status_read_data: assert property (
    rd_isr
    |=> rd_valid && rd_data == $past(isr_value))
    else $error("status read did not return the reported byte");

  c_status_read_tx: cover property (rd_isr && isr_value[5:0] == ISR_CODE_TX_READY);
  c_wake_clear: cover property (rd_isr && st_r.wake_p);
  c_tx_empty_set: cover property (tx_set && tx_count == '0);
  c_fifo_reset: cover property (wr_qctl && host_req.wdata[QC_FIFO_EN] && host_req.wdata[QC_RX_RST]);
  c_pin_irq_bit6: cover property (isr_value[7] && !isr_value[6]);

endmodule // uart_interrupt_fifo_control

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
module host_model
  import uart_irq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output host_req_t       host_req
);
  initial host_req = '0;

  // strobes move on the falling edge so the block samples them settled
  task automatic host_access(input logic wr, input logic [2:0] addr, input logic [7:0] wdata,
                             output logic [7:0] data, output logic ok);
    @(negedge clock);
    host_req = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    @(negedge clock);
    host_req = '0;
    ok = wr;
    data = 8'h00;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end else
        @(negedge clock);
    end
  endtask
endmodule // host_model

// ---- verif/uart_interrupt_fifo_control_tb.sv ----
`timescale 1ns/1ps
module uart_interrupt_fifo_control_tb;
  import uart_irq_pkg::*;
  logic         clock, rst, enhanced_en, pin_irq_enabled, rd_valid, irq_pending;
  logic [1:0]   table_sel;
  logic [7:0]   rx_count, tx_count, prog_rx_level, prog_tx_level, isr_value, rd_data;
  logic [7:0]   rx_trigger, tx_trigger, d;
  host_req_t    host_req;
  uart_events_t events;
  queue_ctl_t   queue_ctl;
  int           mismatches, num_checks;
  logic [7:0]   rx_exp [3][4] = '{'{8'h01, 8'h04, 8'h08, 8'h0E}, '{8'h08, 8'h10, 8'h18, 8'h1C},
                                  '{8'h08, 8'h10, 8'h38, 8'h3C}};
  logic [7:0]   tx_exp [3][4] = '{'{8'h01, 8'h01, 8'h01, 8'h01}, '{8'h10, 8'h08, 8'h18, 8'h1E},
                                  '{8'h08, 8'h10, 8'h20, 8'h38}};

  uart_interrupt_fifo_control u_dut (.clock(clock), .rst(rst), .host_req(host_req),
    .events(events), .rx_count(rx_count), .tx_count(tx_count), .enhanced_en(enhanced_en),
    .table_sel(table_sel), .prog_rx_level(prog_rx_level), .prog_tx_level(prog_tx_level),
    .pin_irq_enabled(pin_irq_enabled), .isr_value(isr_value), .rd_data(rd_data),
    .rd_valid(rd_valid), .queue_ctl(queue_ctl), .rx_trigger(rx_trigger),
    .tx_trigger(tx_trigger), .irq_pending(irq_pending));
  host_model u_host (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
    .host_req(host_req));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] data);
    logic ok;
    u_host.host_access(1'b0, a, 8'h00, data, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t read answer never came", $time);
      stop_test();
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    logic [7:0] unused;
    logic       ok;
    u_host.host_access(1'b1, a, v, unused, ok);
  endtask

  task automatic pulse(input uart_events_t e);
    @(negedge clock);
    events = e;
    @(negedge clock);
    events = '0;
  endtask

  // a flag lands one edge after its cause and the status byte one edge later
  task automatic want(input logic [5:0] code);
    repeat (2) @(negedge clock);
    chk({2'h0, isr_value[5:0]}, {2'h0, code}, "status code");
    chk({7'h00, irq_pending}, {7'h00, code != 6'h01}, "pending flag");
  endtask

  task automatic t_reset;
    chk(isr_value, 8'h01, "status after reset");
    chk({4'h0, queue_ctl}, 8'h00, "control after reset");
    chk(rx_trigger, 8'h01, "rx trigger after reset");
  endtask

  task automatic t_triggers;
    enhanced_en = 1'b1;
    for (int t = 0; t < 3; t++) begin
      for (int s = 0; s < 4; s++) begin
        table_sel = 2'(t);
        wr(3'h2, {2'(s), 2'(s), 4'h1});
        repeat (2) @(negedge clock);
        chk(rx_trigger, rx_exp[t][s], "rx trigger");
        chk(tx_trigger, tx_exp[t][s], "tx trigger");
      end
    end
    table_sel = 2'h3;
    wr(3'h2, 8'h01);
    repeat (2) @(negedge clock);
    chk(rx_trigger, prog_rx_level, "programmed rx trigger");
    chk(tx_trigger, prog_tx_level, "programmed tx trigger");
    chk({7'h00, isr_value[7]}, 8'h01, "fifo enabled bit");
    table_sel = 2'h0;
    wr(3'h2, 8'h01);
  endtask

  task automatic t_control;
    wr(3'h2, 8'h07);
    chk({6'h00, queue_ctl.rx_rst, queue_ctl.tx_rst}, 8'h03, "fifo reset pulses");
    @(negedge clock);
    chk({6'h00, queue_ctl.rx_rst, queue_ctl.tx_rst}, 8'h00, "pulses self clear");
    wr(3'h2, 8'h06);
    chk({4'h0, queue_ctl}, 8'h00, "resets ignored with fifo off");
    repeat (2) @(negedge clock);
    chk({7'h00, isr_value[7]}, 8'h00, "fifo disabled bit");
    enhanced_en = 1'b0;
    wr(3'h2, 8'h09);
    chk({7'h00, queue_ctl.wake_en}, 8'h00, "wake enable needs enhanced");
    enhanced_en = 1'b1;
    wr(3'h2, 8'h09);
    chk({7'h00, queue_ctl.wake_en}, 8'h01, "wake enable set");
    wr(3'h2, 8'h01);
  endtask

  task automatic t_priority;
    logic [2:0] addrs [5] = '{3'h5, 3'h0, 3'h6, 3'h4, 3'h2};
    foreach (addrs[i]) rd(addrs[i], d);
    want(6'h01);
    pulse('{line_err: 1'b1, rx_timeout: 1'b1, modem_change: 1'b1, xonxoff_match: 1'b1,
            default: 1'b0});
    rx_count = 8'h01;
    tx_count = 8'h00;
    want(6'h06);
    rd(3'h5, d);
    want(6'h0C);
    rd(3'h0, d);
    want(6'h04);
    rx_count = 8'h00;
    want(6'h02);
    rd(3'h2, d);
    chk({2'h0, d[5:0]}, 8'h02, "status read returns top source");
    want(6'h00);
    rd(3'h6, d);
    want(6'h10);
    rd(3'h2, d);
    want(6'h01);
    tx_count = 8'h02;
    repeat (2) @(negedge clock);
    tx_count = 8'h00;
    want(6'h02);
    wr(3'h0, 8'h55);
    want(6'h01);
    pulse('{rts_rise: 1'b1, default: 1'b0});
    want(6'h20);
    rd(3'h6, d);
    want(6'h01);
    pulse('{special_match: 1'b1, default: 1'b0});
    want(6'h10);
    pulse('{char_received: 1'b1, default: 1'b0});
    want(6'h01);
    pulse('{gpio_event: 1'b1, default: 1'b0});
    want(6'h01);
    chk({6'h00, isr_value[7:6]}, 8'h02, "pin interrupt bit");
    rd(3'h4, d);
    repeat (2) @(negedge clock);
    chk({6'h00, isr_value[7:6]}, 8'h03, "pin interrupt cleared");
  endtask

  initial begin
    rst = 1'b1;
    events = '0;
    enhanced_en = 1'b0;
    pin_irq_enabled = 1'b1;
    table_sel = 2'h0;
    rx_count = 8'h00;
    tx_count = 8'h02;
    prog_rx_level = 8'h21;
    prog_tx_level = 8'h05;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_triggers();
    t_control();
    t_priority();
    stop_test();
  end
endmodule // uart_interrupt_fifo_control_tb
